// File: verilog/fdc_params.svh
// Constants for the floppy head positioning controller.
// Assumes a 50 MHz core clock and an 8-bit I/O register port.
//
// Contract
// - Matching track, bad CRC: flag, check next
// - No good ID in 5 revolutions: seek error
// - Force interrupt shows drive lines, immediate option
// - Force interrupt on index or ready change
// - Write raises gate, bytes MFM-encoded serially
// - Precompensation only on tracks above 43
// - Step pulses 2 us wide, at rate
// - Steps adjust track register by direction
// - Four drive inputs readable through status
// - Command register at 40H, write only
// - Busy bit set while command runs
// - Decode four command classes
// - Status register at 40H, read only
// - Track register 42H, read write, stepped
// - Sector register 44H, advanced on multi-sector
// - Data register 46H holds seek target
// - Every positioning command ends with interrupt
// - Positioning words carry verify, rate, update
// - Rate bits select 3, 6, 10, 15 ms
// - Verify compares ID track, checks CRC
// - Direction high away from track zero
// - Restore gives up after 255 pulses
// - Seek steps until track equals data
// - Step commands update track only if flagged
`ifndef FDC_PARAMS_SVH
`define FDC_PARAMS_SVH
// Register addresses
`define ADDR_CMD 8'h40
`define ADDR_TRK 8'h42
`define ADDR_SEC 8'h44
`define ADDR_DAT 8'h46
// Opcodes, upper nibble
`define OP_RESTORE 4'h0
`define OP_SEEK 4'h1
`define OP_FORCE 4'hd
`define OP_WR_TRACK 4'hf
// Status bit positions
`define ST_BUSY 0
`define ST_INDEX 1
`define ST_TRK0 2
`define ST_CRC 3
`define ST_SEEK 4
`define ST_PROT 6
`define ST_NRDY 7
// Timing
`define CLK_MHZ 50
`define STEP_PULSE_US 2
`define STEP_PULSE_CYC (`STEP_PULSE_US * `CLK_MHZ)
`define RATE0_US 3000
`define RATE1_US 6000
`define RATE2_US 10000
`define RATE3_US 15000
`define CELL_HALF_NS 1000
`define HALF_CYC (`CELL_HALF_NS * `CLK_MHZ / 1000)
`define WD_PULSE_CYC 6'd10
`define PRECOMP_CYC 6'd5
// Limits
`define PRECOMP_TRACK 8'd43
`define RESTORE_MAX 8'd255
`define VERIFY_REVS 3'd5
`define SECTOR_LAST 9'd511
`define FIFO_DEPTH 8
`endif

// File: verilog/fdc_pkg.sv
// Types shared by the floppy controller design.
// Assumes fdc_params.svh supplies the numeric constants.
package fdc_pkg;
  // Host register access, one cycle per access
  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } io_req_t;
  // ID field from the read decoder
  typedef struct packed {
    logic [7:0] track;
    logic       crc_ok;
  } id_field_t;
  // Command classes
  typedef enum logic [1:0] {CLS_POSITION, CLS_SECTOR, CLS_FORMAT, CLS_FORCE} cmd_class_t;
  // Sequencer states
  typedef enum logic [3:0] {
    S_IDLE, S_CHECK, S_ARM, S_PULSE, S_RATE, S_VERIFY, S_XSTART, S_WRITE, S_WEND, S_END
  } seq_state_t;
endpackage

// File: verilog/floppy_head_position_ctrl.sv
// Floppy controller core: head stepping, verify, force interrupt, MFM write.
// Assumes drive inputs synchronous to core_clk and a decoder delivering ID fields.
`include "fdc_params.svh"

// Byte buffer between data register and encoder
module xfer_fifo #(
  parameter int W = 8,
  parameter int D = 8
) (
  // Clock and reset
  input  wire logic         clk,
  input  wire logic         rst_n,
  // Fill side
  input  wire logic [W-1:0] in_data,
  input  wire logic         in_valid,
  output logic              in_ready,
  // Drain side
  output logic [W-1:0]      out_data,
  output logic              out_valid,
  input  wire logic         out_ready
);
  localparam int AW = $clog2(D);
  localparam logic [AW:0] FULL = (AW + 1)'(D);
  logic [W-1:0] mem [D];   // Storage
  logic [AW:0]  wp;        // Write pointer, wrap bit on top
  logic [AW:0]  rp;        // Read pointer
  logic [AW:0]  fill;      // Words held
  assign fill      = wp - rp;
  assign in_ready  = fill != FULL;
  assign out_valid = fill != '0;
  assign out_data  = mem[rp[AW-1:0]];
  // Storage write
  always_ff @(posedge clk)
  begin
    if (in_valid && in_ready)
      mem[wp[AW-1:0]] <= in_data;
  end
  // Pointers
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      wp <= '0;
      rp <= '0;
    end
    else
    begin
      if (in_valid && in_ready)
        wp <= wp + 1'b1;
      if (out_valid && out_ready)
        rp <= rp + 1'b1;
    end
  end
endmodule

module floppy_head_position_ctrl #(
  parameter int unsigned RATE0_CYC = `RATE0_US * `CLK_MHZ,
  parameter int unsigned RATE1_CYC = `RATE1_US * `CLK_MHZ,
  parameter int unsigned RATE2_CYC = `RATE2_US * `CLK_MHZ,
  parameter int unsigned RATE3_CYC = `RATE3_US * `CLK_MHZ
) (
  // Clock and reset
  input  wire logic               core_clk,
  input  wire logic               rst_n,
  // Host register port
  input  wire fdc_pkg::io_req_t   io_req,
  output logic [7:0]              io_rdata,
  output logic                    completion_irq,
  output logic                    data_request,
  // Drive status inputs
  input  wire logic               drive_ready_in,
  input  wire logic               track_zero_in,
  input  wire logic               index_pulse_in,
  input  wire logic               write_protect_in,
  // ID fields from the read decoder
  input  wire fdc_pkg::id_field_t id_field,
  input  wire logic               id_valid,
  // Drive control outputs
  output logic                    step_out,
  output logic                    dirc_out,
  output logic                    write_gate,
  output logic                    write_data
);
  localparam logic [5:0] HALF_M1 = 6'(`HALF_CYC - 1);
  localparam logic [19:0] PULSE_M1 = 20'(`STEP_PULSE_CYC - 1);

  fdc_pkg::seq_state_t state;   // Sequencer state
  fdc_pkg::cmd_class_t new_cls; // Class of written word
  logic [7:0]  command_word;          // Current command
  logic [7:0]  head_track_position;   // Track register
  logic [7:0]  target_sector_number;  // Sector register
  logic [7:0]  transfer_holding_byte; // Data register
  logic [7:0]  controller_condition;  // Status view
  logic        busy;                  // Command running
  logic        xfer;                  // Transfer status layout
  logic        seek_err;              // Seek or not-found error
  logic        crc_err;               // ID CRC error
  logic        lost;                  // Lost data
  logic        done_pulse;            // Command finished
  logic [7:0]  steps;                 // Pulses issued
  logic [2:0]  revs;                  // Index pulses in verify
  logic [19:0] tmr;                   // Step timer
  logic [19:0] rate_m1;               // Selected interval
  logic [8:0]  bytes;                 // Bytes in sector
  logic [3:0]  fint;                  // Force interrupt conditions
  logic        idx_q;                 // Index, last cycle
  logic        rdy_q;                 // Ready, last cycle
  logic [7:0]  hi_cnt;                // Step high length, checked
  // Encoder state
  logic        enc_busy;
  logic        enc_prev;
  logic        enc_half;
  logic [7:0]  enc_sr;
  logic [2:0]  enc_bit;
  logic [5:0]  enc_tmr;
  logic [5:0]  elapsed;
  logic [5:0]  shift;
  logic        cell_one;
  // Buffer wires
  logic [7:0]  fifo_d;
  logic        fifo_ov;
  logic        fifo_ir;

  // Access decode
  wire [3:0] new_op    = io_req.wdata[7:4];
  wire       cmd_wr    = io_req.wr && io_req.addr == `ADDR_CMD;
  wire       status_rd = io_req.rd && io_req.addr == `ADDR_CMD;
  wire       trk_wr    = io_req.wr && io_req.addr == `ADDR_TRK;
  wire       sec_wr    = io_req.wr && io_req.addr == `ADDR_SEC;
  wire       dat_wr    = io_req.wr && io_req.addr == `ADDR_DAT;
  // Command fields
  wire [3:0] op        = command_word[7:4];
  wire       verify    = command_word[3];
  wire       upd       = command_word[7:5] == 3'b000 || command_word[4];
  wire       wr_cmd    = op[3:1] == 3'b101 || op == `OP_WR_TRACK;
  wire       multi     = op[3:1] == 3'b101 && command_word[4];
  wire       idx_rise  = index_pulse_in && !idx_q;
  wire       trk_match = id_valid && id_field.track == head_track_position;
  wire       precomp   = head_track_position > `PRECOMP_TRACK;
  wire       enc_run   = state == fdc_pkg::S_WRITE;
  wire       enc_end   = enc_busy && enc_tmr == 6'h00 && enc_half && enc_bit == 3'h0;
  wire       enc_load  = enc_run && write_gate && (!enc_busy || enc_end);
  wire       fint_evt  = (fint[2] && idx_rise) || (|fint[1:0] && rdy_q != drive_ready_in);
  wire       fint_now  = cmd_wr && new_op == `OP_FORCE && io_req.wdata[3];
  wire       irq_set   = done_pulse || fint_evt || fint_now;
  wire fdc_pkg::seq_state_t fin_st = verify ? fdc_pkg::S_VERIFY : fdc_pkg::S_END;

  // Class of a written command word
  always_comb
  begin
    if (!new_op[3])
      new_cls = fdc_pkg::CLS_POSITION;
    else if (new_op == `OP_FORCE)
      new_cls = fdc_pkg::CLS_FORCE;
    else if (new_op[3:2] == 2'b10)
      new_cls = fdc_pkg::CLS_SECTOR;
    else
      new_cls = fdc_pkg::CLS_FORMAT;
  end

  // Step interval from the rate bits
  always_comb
  begin
    case (command_word[1:0])
      2'b00:   rate_m1 = 20'(RATE0_CYC - 1);
      2'b01:   rate_m1 = 20'(RATE1_CYC - 1);
      2'b10:   rate_m1 = 20'(RATE2_CYC - 1);
      default: rate_m1 = 20'(RATE3_CYC - 1);
    endcase
  end

  // Status view, drive lines live; index and track zero bits replaced from a sector or format command until a positioning or force command
  always_comb
  begin
    controller_condition            = 8'h00;
    controller_condition[`ST_BUSY]  = busy;
    controller_condition[`ST_INDEX] = xfer ? data_request : !index_pulse_in;
    controller_condition[`ST_TRK0]  = xfer ? lost : !track_zero_in;
    controller_condition[`ST_CRC]   = crc_err;
    controller_condition[`ST_SEEK]  = seek_err;
    controller_condition[`ST_PROT]  = !write_protect_in;
    controller_condition[`ST_NRDY]  = !drive_ready_in;
  end

  // Command sequencer and host registers
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state                 <= fdc_pkg::S_IDLE;
      command_word          <= 8'h00;
      head_track_position   <= 8'h00;
      target_sector_number  <= 8'h00;
      transfer_holding_byte <= 8'h00;
      busy                  <= 1'b0;
      xfer                  <= 1'b0;
      seek_err              <= 1'b0;
      crc_err               <= 1'b0;
      lost                  <= 1'b0;
      done_pulse            <= 1'b0;
      steps                 <= 8'h00;
      revs                  <= 3'h0;
      tmr                   <= 20'h00000;
      bytes                 <= 9'h000;
      step_out              <= 1'b0;
      dirc_out              <= 1'b0;
      write_gate            <= 1'b0;
    end
    else
    begin
      done_pulse <= 1'b0;
      // Host writes; track and sector registers locked while busy, data register always writable
      if (trk_wr && !busy)
        head_track_position <= io_req.wdata;
      if (sec_wr && !busy)
        target_sector_number <= io_req.wdata;
      if (dat_wr)
        transfer_holding_byte <= io_req.wdata;
      if (cmd_wr && new_cls == fdc_pkg::CLS_FORCE)
      begin
        // Abort and show drive lines
        command_word <= io_req.wdata;
        state        <= fdc_pkg::S_IDLE;
        busy         <= 1'b0;
        xfer         <= 1'b0;
        step_out     <= 1'b0;
        write_gate   <= 1'b0;
      end
      else if (cmd_wr && !busy)
      begin
        // Accept a new command
        command_word <= io_req.wdata;
        busy         <= 1'b1;
        xfer         <= new_cls != fdc_pkg::CLS_POSITION;
        seek_err     <= 1'b0;
        crc_err      <= 1'b0;
        lost         <= 1'b0;
        steps        <= 8'h00;
        bytes        <= 9'h000;
        state        <= new_cls == fdc_pkg::CLS_POSITION ? fdc_pkg::S_CHECK : fdc_pkg::S_XSTART;
        if (new_op == `OP_RESTORE || new_op[3:1] == 3'b011)
          dirc_out <= 1'b0;
        else if (new_op[3:1] == 3'b010)
          dirc_out <= 1'b1;
      end
      else
      begin
        case (state)
          fdc_pkg::S_CHECK:
          begin
            revs <= 3'h0;
            if (op == `OP_RESTORE)
            begin
              if (!track_zero_in)
              begin
                head_track_position <= 8'h00;
                state               <= fin_st;
              end
              else if (steps == `RESTORE_MAX)
              begin
                seek_err <= 1'b1;
                state    <= fdc_pkg::S_END;
              end
              else
                state <= fdc_pkg::S_ARM;
            end
            else if (op == `OP_SEEK)
            begin
              if (head_track_position == transfer_holding_byte)
                state <= fin_st;
              else
              begin
                dirc_out <= transfer_holding_byte > head_track_position;
                state    <= fdc_pkg::S_ARM;
              end
            end
            else
              state <= steps != 8'h00 ? fin_st : fdc_pkg::S_ARM;
          end
          fdc_pkg::S_ARM:
          begin
            // Pulse starts a cycle after direction settles
            step_out <= 1'b1;
            steps    <= steps + 8'h01;
            tmr      <= PULSE_M1;
            state    <= fdc_pkg::S_PULSE;
            if (upd)
              head_track_position <= dirc_out ? head_track_position + 8'h01 : head_track_position - 8'h01;
          end
          fdc_pkg::S_PULSE:
          begin
            if (tmr == 20'h00000)
            begin
              step_out <= 1'b0;
              tmr      <= rate_m1;
              state    <= fdc_pkg::S_RATE;
            end
            else
              tmr <= tmr - 20'h00001;
          end
          fdc_pkg::S_RATE:
          begin
            // Interval also serves as settle before verify
            if (tmr == 20'h00000)
              state <= fdc_pkg::S_CHECK;
            else
              tmr <= tmr - 20'h00001;
          end
          fdc_pkg::S_VERIFY:
          begin
            if (idx_rise && revs == `VERIFY_REVS - 3'h1)
            begin
              seek_err <= 1'b1;
              state    <= fdc_pkg::S_END;
            end
            else
            begin
              if (idx_rise)
                revs <= revs + 3'h1;
              if (trk_match && id_field.crc_ok)
                state <= fdc_pkg::S_END;
              else if (trk_match)
                crc_err <= 1'b1;
            end
          end
          fdc_pkg::S_XSTART:
          begin
            // Not ready or protected aborts; lines show in status
            if (drive_ready_in && wr_cmd && write_protect_in)
              state <= fdc_pkg::S_WRITE;
            else
              state <= fdc_pkg::S_END;
          end
          fdc_pkg::S_WRITE:
          begin
            if (fifo_ov)
              write_gate <= 1'b1;
            if (enc_load)
            begin
              bytes <= bytes + 9'h001;
              if (!fifo_ov)
                lost <= 1'b1;
              if (bytes == `SECTOR_LAST && multi)
                target_sector_number <= target_sector_number + 8'h01;
              else if (bytes == `SECTOR_LAST)
                state <= fdc_pkg::S_WEND;
            end
          end
          fdc_pkg::S_WEND:
          begin
            if (!enc_busy)
            begin
              write_gate <= 1'b0;
              state      <= fdc_pkg::S_END;
            end
          end
          fdc_pkg::S_END:
          begin
            busy       <= 1'b0;
            done_pulse <= 1'b1;
            state      <= fdc_pkg::S_IDLE;
          end
          default:
            state <= fdc_pkg::S_IDLE;
        endcase
      end
    end
  end

  // Drive line history
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      idx_q <= 1'b0;
      rdy_q <= 1'b1; // Idle level of ready, no false edge after reset
    end
    else
    begin
      idx_q <= index_pulse_in;
      rdy_q <= drive_ready_in;
    end
  end

  // Interrupt; a set beats a clear
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      fint           <= 4'h0;
      completion_irq <= 1'b0;
    end
    else
    begin
      if (cmd_wr)
        fint <= new_op == `OP_FORCE ? io_req.wdata[3:0] : 4'h0;
      if (irq_set)
        completion_irq <= 1'b1;
      else if (cmd_wr || status_rd)
        completion_irq <= 1'b0;
    end
  end

  // Read data and byte request
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      io_rdata     <= 8'h00;
      data_request <= 1'b0;
    end
    else
    begin
      data_request <= enc_run && fifo_ir;
      if (!io_req.rd)
        io_rdata <= 8'h00;
      else
        case (io_req.addr)
          `ADDR_CMD: io_rdata <= controller_condition;
          `ADDR_TRK: io_rdata <= head_track_position;
          `ADDR_SEC: io_rdata <= target_sector_number;
          `ADDR_DAT: io_rdata <= transfer_holding_byte;
          default:   io_rdata <= 8'h00;
        endcase
    end
  end

  // Byte buffer; data writes fill it during a disk write
  xfer_fifo #(
    .W (8),
    .D (`FIFO_DEPTH)
  ) u_fifo (
    .clk       (core_clk),
    .rst_n     (rst_n),
    .in_data   (io_req.wdata),
    .in_valid  (dat_wr && enc_run),
    .in_ready  (fifo_ir),
    .out_data  (fifo_d),
    .out_valid (fifo_ov),
    .out_ready (enc_load)
  );

  // MFM cell: clock bit only between two zeros
  always_comb
  begin
    cell_one = enc_half ? enc_sr[7] : (!enc_prev && !enc_sr[7]);
    elapsed  = HALF_M1 - enc_tmr;
    shift    = (precomp && enc_prev && cell_one) ? `PRECOMP_CYC : 6'h00;
  end

  // Serial encoder; empty buffer sends a zero byte
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      enc_busy <= 1'b0;
      enc_prev <= 1'b0;
      enc_half <= 1'b0;
      enc_sr   <= 8'h00;
      enc_bit  <= 3'h0;
      enc_tmr  <= 6'h00;
    end
    else if (enc_load)
    begin
      enc_busy <= 1'b1;
      enc_prev <= enc_busy ? enc_sr[7] : 1'b0;
      enc_sr   <= fifo_ov ? fifo_d : 8'h00;
      enc_bit  <= 3'h7;
      enc_half <= 1'b0;
      enc_tmr  <= HALF_M1;
    end
    else if (enc_busy)
    begin
      if (enc_tmr != 6'h00)
        enc_tmr <= enc_tmr - 6'h01;
      else
      begin
        enc_tmr  <= HALF_M1;
        enc_half <= !enc_half;
        if (enc_half)
        begin
          enc_prev <= enc_sr[7];
          enc_sr   <= {enc_sr[6:0], 1'b0};
          enc_bit  <= enc_bit - 3'h1;
          if (enc_bit == 3'h0)
            enc_busy <= 1'b0;
        end
      end
    end
  end

  // Write pulse inside its half cell; an abort silences it with the gate
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
      write_data <= 1'b0;
    else
      write_data <= enc_busy && write_gate && !(cmd_wr && new_op == `OP_FORCE) && cell_one
                    && elapsed >= shift && elapsed < shift + `WD_PULSE_CYC;
  end

  // Step high length, for checking only
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
      hi_cnt <= 8'h00;
    else
      hi_cnt <= step_out ? hi_cnt + 8'h01 : 8'h00;
  end

  a_step_width: assert property (@(posedge core_clk) disable iff (!rst_n)
    $fell(step_out) |-> hi_cnt == 8'(`STEP_PULSE_CYC)) else $error("step pulse width wrong");
  a_dir_setup: assert property (@(posedge core_clk) disable iff (!rst_n)
    $rose(step_out) |-> $stable(dirc_out)) else $error("direction moved with step");
  a_track_follow: assert property (@(posedge core_clk) disable iff (!rst_n)
    state == fdc_pkg::S_ARM && upd && !cmd_wr |=> head_track_position ==
      ($past(dirc_out) ? $past(head_track_position) + 8'h01 : $past(head_track_position) - 8'h01))
    else $error("track register not stepped");
  a_irq_clear: assert property (@(posedge core_clk) disable iff (!rst_n)
    (cmd_wr || status_rd) && !irq_set |=> !completion_irq) else $error("interrupt not cleared");
  a_end_irq: assert property (@(posedge core_clk) disable iff (!rst_n)
    state == fdc_pkg::S_END |=> !busy ##1 completion_irq) else $error("no interrupt at end");
  a_busy_cmd: assert property (@(posedge core_clk) disable iff (!rst_n)
    cmd_wr && !busy && new_cls != fdc_pkg::CLS_FORCE |=> busy) else $error("busy not set");
  a_verify_timeout: assert property (@(posedge core_clk) disable iff (!rst_n)
    state == fdc_pkg::S_VERIFY && idx_rise && revs == 3'h4 && !cmd_wr |=> seek_err ##1 !busy)
    else $error("verify did not time out");
  a_crc_retry: assert property (@(posedge core_clk) disable iff (!rst_n)
    state == fdc_pkg::S_VERIFY && trk_match && !id_field.crc_ok && !idx_rise && !cmd_wr
      |=> crc_err && state == fdc_pkg::S_VERIFY) else $error("CRC error not kept");
  a_restore_limit: assert property (@(posedge core_clk) disable iff (!rst_n)
    state == fdc_pkg::S_CHECK && op == `OP_RESTORE && track_zero_in && steps == `RESTORE_MAX && !cmd_wr
      |=> seek_err) else $error("restore limit missed");
  a_gate_data: assert property (@(posedge core_clk) disable iff (!rst_n)
    write_data |-> write_gate) else $error("write data without gate");
endmodule

// File: testbench/drive_model.sv
// Behavioural floppy drive: head position, track zero, index and status lines.
// Assumes the controller's step and direction outputs change on core_clk.
module drive_model (
  // Clock
  input  wire logic core_clk,
  // Head control
  input  wire logic step_out,
  input  wire logic dirc_out,
  // Drive status lines
  output logic      drive_ready_in,
  output logic      track_zero_in,
  output logic      index_pulse_in,
  output logic      write_protect_in
);
  timeunit 1ns;
  timeprecision 1ps;
  int pos   = 2; // Head position, starts off track zero
  int width = 0; // Length of the last step pulse
  int run   = 0; // Cycles of the current pulse
  int rev   = 0; // Cycle within a revolution
  initial
  begin
    // Drive ready, not write protected, head off track zero, index low
    drive_ready_in   = 1'b1;
    write_protect_in = 1'b1;
    track_zero_in    = 1'b1;
    index_pulse_in   = 1'b0;
  end
  // Head moves one track per pulse
  always @(posedge step_out)
    pos = dirc_out ? pos + 1 : pos - 1;
  // Pulse width, track zero and index timing
  always @(negedge core_clk)
  begin
    run = step_out ? run + 1 : 0;
    if (run != 0)
      width = run;
    track_zero_in  = (pos != 0);
    rev            = (rev + 1) % 500;
    index_pulse_in = (rev == 0);
  end
endmodule

// File: testbench/tb_top.sv
// Self-checking bench for the head positioning controller.
// Assumes drive_model plays the drive; shortened step rates.
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic             core_clk = 1'b0; // 50 MHz clock
  logic             rst_n    = 1'b0; // Reset, active low
  fdc_pkg::io_req_t io_req   = '0;   // Host access
  logic [7:0]       io_rdata;
  logic             completion_irq, data_request, step_out, dirc_out, write_gate, write_data;
  logic             drive_ready_in, track_zero_in, index_pulse_in, write_protect_in;
  int               failures = 0;
  int               n_tests  = 0;
  int               m_trk;           // Model track register
  logic [7:0]       v, r;            // Read value, random value
  fdc_pkg::id_field_t id_f   = '0;   // ID field from the bench decoder
  logic             id_v     = 1'b0; // ID field strobe
  int               n_wd     = 0;    // Write data pulses seen
  int               m_mfm;           // Model pulse count
  logic             p_bit;           // Model previous data bit
  time              t_fall, t_irq;   // Step fall, interrupt seen
  int               rate_cyc[4] = '{20, 30, 40, 50}; // Bench step intervals
  always @(negedge step_out) t_fall = $time;
  always @(posedge write_data) n_wd++;
  always #10 core_clk = ~core_clk;
  floppy_head_position_ctrl #(.RATE0_CYC(20), .RATE1_CYC(30), .RATE2_CYC(40), .RATE3_CYC(50)) dut (
    .core_clk(core_clk), .rst_n(rst_n), .io_req(io_req), .io_rdata(io_rdata),
    .completion_irq(completion_irq), .data_request(data_request), .drive_ready_in(drive_ready_in),
    .track_zero_in(track_zero_in), .index_pulse_in(index_pulse_in), .write_protect_in(write_protect_in),
    .id_field(id_f), .id_valid(id_v), .step_out(step_out), .dirc_out(dirc_out),
    .write_gate(write_gate), .write_data(write_data));
  drive_model drv (.core_clk(core_clk), .step_out(step_out), .dirc_out(dirc_out),
    .drive_ready_in(drive_ready_in), .track_zero_in(track_zero_in),
    .index_pulse_in(index_pulse_in), .write_protect_in(write_protect_in));
  // Compare and count
  task automatic check(input string nm, input logic [7:0] e, input logic [7:0] g);
    n_tests++;
    if (g !== e)
    begin
      failures++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask
  // Counts and verdict
  task automatic print_verdict;
    $display("checks %0d mismatches %0d", n_tests, failures);
    if (failures == 0 && n_tests > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  // One-cycle register write
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge core_clk);
    io_req = '{1'b1, 1'b0, a, d};
    @(negedge core_clk);
    io_req = '0;
  endtask
  // One-cycle register read, data a cycle later
  task automatic rd(input logic [7:0] a);
    @(negedge core_clk);
    io_req = '{1'b0, 1'b1, a, 8'h00};
    @(negedge core_clk);
    io_req = '0;
    v = io_rdata;
  endtask
  // Bounded wait for the interrupt
  task automatic wait_irq;
    for (int i = 0; i < 3000; i++)
    begin
      @(negedge core_clk);
      if (completion_irq === 1'b1)
      begin
        t_irq = $time;
        return;
      end
    end
    failures++;
    print_verdict;
  endtask
  // Command, completion, status read clears interrupt
  task automatic run(input logic [7:0] c);
    wr(8'h40, c);
    wait_irq;
    rd(8'h40);
    check("irq", 8'h00, {7'h00, completion_irq});
  endtask
  initial
  begin
    void'($urandom(93));
    repeat (3) @(negedge core_clk);
    rst_n = 1'b1;
    r = $urandom;
    wr(8'h42, r);
    rd(8'h42);
    check("track", r, v);
    wr(8'h44, r + 8'h01);
    rd(8'h44);
    check("sector", r + 8'h01, v);
    wr(8'h46, ~r);
    rd(8'h46);
    check("data", ~r, v);
    rd(8'h48);
    check("unmapped", 8'h00, v);
    $display("registers done");
    run(8'h00);
    rd(8'h42);
    check("restore track", 8'h00, v);
    rd(8'h40);
    check("status", 8'h04, v & 8'hfd);
    $display("restore done");
    m_trk = 1 + $urandom % 6;
    wr(8'h46, m_trk[7:0]);
    wr(8'h40, 8'h10);
    rd(8'h40);
    check("busy", 8'h01, v & 8'h01);
    wait_irq;
    rd(8'h42);
    check("seek track", m_trk[7:0], v);
    check("head", m_trk[7:0], drv.pos[7:0]);
    check("dirc", 8'h01, {7'h00, dirc_out});
    check("step width", 8'h64, drv.width[7:0]);
    $display("seek done");
    for (int k = 0; k < 4; k++)
    begin
      run(8'h50 | k[7:0]);
      check("step rate", 8'(rate_cyc[k] + 3), 8'((t_irq - t_fall) / 20));
      m_trk++;
      rd(8'h42);
      check("step in", m_trk[7:0], v);
    end
    run(8'h20);
    rd(8'h42);
    check("no update", m_trk[7:0], v);
    run(8'h70);
    m_trk--;
    rd(8'h42);
    check("step out", m_trk[7:0], v);
    check("dirc low", 8'h00, {7'h00, dirc_out});
    $display("steps done");
    wr(8'h46, m_trk[7:0]);
    wr(8'h40, 8'h18);
    repeat (2) @(negedge core_clk);
    id_f = '{m_trk[7:0], 1'b0};
    id_v = 1'b1;
    @(negedge core_clk);
    id_f = '{m_trk[7:0], 1'b1};
    @(negedge core_clk);
    id_v = 1'b0;
    wait_irq;
    rd(8'h40);
    check("crc status", 8'h08, v & 8'h18);
    wr(8'h40, 8'h18);
    wait_irq;
    rd(8'h40);
    check("verify timeout", 8'h10, v & 8'h18);
    $display("verify done");
    n_wd = 0;
    wr(8'h40, 8'ha0);
    wr(8'h46, r);
    repeat (790) @(negedge core_clk);
    check("gate", 8'h01, {7'h00, write_gate});
    check("byte req", 8'h01, {7'h00, data_request});
    m_mfm = 0;
    p_bit = 1'b0;
    for (int i = 7; i >= 0; i--)
    begin
      m_mfm += r[i] + (!p_bit && !r[i]);
      p_bit = r[i];
    end
    check("mfm pulses", m_mfm[7:0], n_wd[7:0]);
    wr(8'h40, 8'hd0);
    @(negedge core_clk);
    check("gate off", 8'h00, {7'h00, write_gate});
    $display("write done");
    run(8'hd8);
    wr(8'h40, 8'hd4);
    wait_irq;
    rd(8'h40);
    check("force status", 8'h00, v & 8'hfc);
    wr(8'h40, 8'hd2);
    @(negedge core_clk);
    drv.drive_ready_in = 1'b0;
    wait_irq;
    rd(8'h40);
    check("not ready", 8'h80, v & 8'h80);
    drv.drive_ready_in = 1'b1;
    $display("force done");
    print_verdict;
  end
endmodule
